/* File: bcd_pkg.sv */
// package: field layout, reset values and decoded-setting types for the boot config decoder
package bcd_pkg;
	// word 0 fields
	localparam int W0_CODE_PROTECT_BIT   = 28;
	localparam int W0_DEBUG_CHAN_BIT     = 3;
	localparam int W0_DEBUG_EN_LSB       = 0;
	// word 1 fields
	localparam int W1_WDT_FUSE_BIT       = 23;
	localparam int W1_WDT_POST_LSB       = 16;
	localparam int W1_CLK_SW_MON_LSB     = 14;
	localparam int W1_PB_DIV_LSB         = 12;
	localparam int W1_CLK_OUT_DIS_BIT    = 10;
	localparam int W1_POSC_MODE_LSB      = 8;
	localparam int W1_TWO_SPEED_BIT      = 7;
	localparam int W1_SOSC_EN_BIT        = 5;
	localparam int W1_STARTUP_OSC_LSB    = 0;
	// word 2 fields
	localparam int W2_PLL_ODIV_LSB       = 16;
	localparam int W2_USB_PLL_BYP_BIT    = 15;
	localparam int W2_USB_PLL_IDIV_LSB   = 8;
	localparam int W2_PLL_MUL_LSB        = 4;
	localparam int W2_PLL_IDIV_LSB       = 0;
	// codes
	localparam logic [1:0] DEBUG_EN_CODE   = 2'h2;
	localparam logic [1:0] DEBUG_OFF_CODE  = 2'h3;
	localparam logic [4:0] WDT_POST_MAX    = 5'h14;
	localparam logic [1:0] POSC_OFF_CODE   = 2'h3;
	localparam logic [1:0] POSC_EXT_CODE   = 2'h0;
	localparam logic [1:0] CSM_SW_ONLY     = 2'h1;
	localparam logic [1:0] CSM_SW_FSCM     = 2'h0;
	// reset values of held settings (all-erased words read as ones)
	localparam logic [31:0] WORD_ERASED    = 32'hFFFF_FFFF;
	// cycles after reset release before settings are flagged valid
	localparam int LOAD_NS                 = 300;
	localparam int CLK_NS                  = 100;
	localparam logic [1:0] LOAD_CYCLES     = 2'((LOAD_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [2:0] {
		OSC_FRC, OSC_FRC_DIVN_PLL, OSC_PRIMARY, OSC_PRIMARY_PLL,
		OSC_SECONDARY, OSC_LOW_POWER_RC, OSC_FRC_DIV16, OSC_FRC_DIVN
	} bcd_osc_e;

	typedef enum logic [1:0] {
		POSC_EXT_CLOCK, POSC_STD_CRYSTAL, POSC_HS_CRYSTAL, POSC_DISABLED
	} bcd_posc_e;

	// the decoded settings handed to clock, watchdog and debug units
	typedef struct packed {
		logic          debug_channel_select;
		logic          debugger_enable;
		logic [1:0]    debug_field_eff;
		logic          code_protect_active;
		logic          watchdog_forced_on;
		logic          watchdog_sw_enable_allowed;
		logic [4:0]    watchdog_postscale_eff;
		logic          clock_switch_enable;
		logic          fail_safe_monitor_enable;
		logic [3:0]    periph_bus_div;
		logic          clock_output_enable;
		bcd_posc_e     primary_osc_mode;
		logic          two_speed_startup_en;
		logic          secondary_osc_en;
		bcd_osc_e      startup_osc_select;
		logic [8:0]    sys_pll_out_div;
		logic          usb_pll_enable;
		logic          usb_pll_bypass;
		logic [3:0]    usb_pll_in_div;
		logic [4:0]    sys_pll_multiplier;
		logic [3:0]    sys_pll_in_div;
	} bcd_cfg_s;

	// whole state of the decoder apart from the read data register
	typedef struct packed {
		bcd_cfg_s      cfg;
		logic [31:0]   word_clock_watchdog;
		logic [31:0]   word_pll;
		logic [1:0]    load_cnt;
		logic          valid;
	} bcd_state_s;
endpackage : bcd_pkg

/* File: bcd_boot_config_word_decoder.sv */
// boot configuration word decoder: samples config words during reset and holds settings
// Summary of operation
// [R1] debug channel bit set selects second programming pair, clear selects first
// [R2] debugger enabled only for code 10; forced to 11 under code protection
// [R3] watchdog fuse set forces watchdog on; clear lets software enable it
// [R4] watchdog postscale ratio is two to the power of the code
// [R5] postscale codes above 10100 behave as 10100
// [R6] upper bit set disables switching and monitor; 01 switching; 00 both
// [R7] peripheral bus clock is system clock divided by 1, 2, 4 or 8
// [R8] clock output only when its disable bit is 0 and oscillator mode 11 or 00
// [R9] primary oscillator mode: 11 off, 10 high-speed, 01 crystal, 00 external
// [R10] switchover bit enables two-speed start-up on internal oscillator
// [R11] secondary oscillator enabled when its bit is 1
// [R12] start-up oscillator field picks one of eight sources
// [R13] programmer should not disable primary oscillator when it is start-up source
// [R14] system pll output divider 1,2,4,8,16,32,64,256
// [R15] usb pll enabled when bit is 0, disabled and bypassed when 1
// [R16] usb pll input divider 1,2,3,4,5,6,10,12
// [R17] system pll multiplier 15..21 then 24
// [R18] programmer writes reserved word positions as ones
// [R19] system pll input divider 1,2,3,4,5,6,10,12
// [R20] code protect bit 0 enables protection
// [R21] settings captured during reset and held while running
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/10ps
module bcd_boot_config_word_decoder (
	// clock and reset
	input  wire logic              CORE_CLK,
	input  wire logic              SRST,
	// programmed configuration memory
	input  wire logic [31:0]       CFG_WORD_DEBUG,
	input  wire logic [31:0]       CFG_WORD_CLOCK_WATCHDOG,
	input  wire logic [31:0]       CFG_WORD_PLL,
	// register port
	input  wire logic [1:0]        REG_ADDR,
	input  wire logic [31:0]       REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic [31:0]            REG_RDATA,
	// decoded settings
	output bcd_pkg::bcd_cfg_s      CFG_OUT,
	output logic                   CFG_VALID
);
	// register indexes
	localparam logic [1:0] IDX_CLOCK_WATCHDOG = 2'h0;
	localparam logic [1:0] IDX_PLL            = 2'h1;
	localparam logic [1:0] IDX_STATUS         = 2'h2;

	bcd_pkg::bcd_state_s st_r;
	bcd_pkg::bcd_state_s st_nxt;
	logic [31:0]         rdata_r;
	logic [31:0]         rdata_nxt;

	// ratio code to divide value for 1,2,3,4,5,6,10,12 input dividers
	function automatic logic [3:0] in_div(input logic [2:0] code);
		unique case (code)
			3'h6:    in_div = 4'hA;
			3'h7:    in_div = 4'hC;
			default: in_div = 4'(code) + 4'h1;
		endcase
	endfunction

	// full decode of the three words into settings
	function automatic bcd_pkg::bcd_cfg_s decode(input logic [31:0] w0, input logic [31:0] w1,
		input logic [31:0] w2);
		bcd_pkg::bcd_cfg_s c;
		logic [1:0]        dbg;
		logic [4:0]        wps;
		logic [1:0]        csm;
		logic [2:0]        odiv;
		logic [2:0]        mul;
		c = '0;
		c.code_protect_active = ~w0[bcd_pkg::W0_CODE_PROTECT_BIT]; // R20
		c.debug_channel_select = w0[bcd_pkg::W0_DEBUG_CHAN_BIT]; // R1
		dbg = w0[bcd_pkg::W0_DEBUG_EN_LSB +: 2];
		if (c.code_protect_active) begin
			dbg = bcd_pkg::DEBUG_OFF_CODE; // R2
		end
		c.debug_field_eff = dbg;
		c.debugger_enable = (dbg == bcd_pkg::DEBUG_EN_CODE); // R2
		c.watchdog_forced_on = w1[bcd_pkg::W1_WDT_FUSE_BIT]; // R3
		c.watchdog_sw_enable_allowed = ~w1[bcd_pkg::W1_WDT_FUSE_BIT]; // R3
		wps = w1[bcd_pkg::W1_WDT_POST_LSB +: 5];
		c.watchdog_postscale_eff = (wps > bcd_pkg::WDT_POST_MAX) ?
			bcd_pkg::WDT_POST_MAX : wps; // R4 R5
		csm = w1[bcd_pkg::W1_CLK_SW_MON_LSB +: 2];
		c.clock_switch_enable = (csm == bcd_pkg::CSM_SW_ONLY) ||
			(csm == bcd_pkg::CSM_SW_FSCM); // R6
		c.fail_safe_monitor_enable = (csm == bcd_pkg::CSM_SW_FSCM); // R6
		c.periph_bus_div = 4'h1 << w1[bcd_pkg::W1_PB_DIV_LSB +: 2]; // R7
		c.primary_osc_mode = bcd_pkg::bcd_posc_e'(w1[bcd_pkg::W1_POSC_MODE_LSB +: 2]); // R9
		c.clock_output_enable = ~w1[bcd_pkg::W1_CLK_OUT_DIS_BIT] &&
			((w1[bcd_pkg::W1_POSC_MODE_LSB +: 2] == bcd_pkg::POSC_OFF_CODE) ||
			 (w1[bcd_pkg::W1_POSC_MODE_LSB +: 2] == bcd_pkg::POSC_EXT_CODE)); // R8
		c.two_speed_startup_en = w1[bcd_pkg::W1_TWO_SPEED_BIT]; // R10
		c.secondary_osc_en = w1[bcd_pkg::W1_SOSC_EN_BIT]; // R11
		c.startup_osc_select = bcd_pkg::bcd_osc_e'(w1[bcd_pkg::W1_STARTUP_OSC_LSB +: 3]); // R12
		odiv = w2[bcd_pkg::W2_PLL_ODIV_LSB +: 3];
		c.sys_pll_out_div = (odiv == 3'h7) ? 9'h100 : (9'h001 << odiv); // R14
		c.usb_pll_bypass = w2[bcd_pkg::W2_USB_PLL_BYP_BIT]; // R15
		c.usb_pll_enable = ~w2[bcd_pkg::W2_USB_PLL_BYP_BIT]; // R15
		c.usb_pll_in_div = in_div(w2[bcd_pkg::W2_USB_PLL_IDIV_LSB +: 3]); // R16
		mul = w2[bcd_pkg::W2_PLL_MUL_LSB +: 3];
		c.sys_pll_multiplier = (mul == 3'h7) ? 5'h18 : (5'h0F + 5'(mul)); // R17
		c.sys_pll_in_div = in_div(w2[bcd_pkg::W2_PLL_IDIV_LSB +: 3]); // R19
		return c;
	endfunction

	// next-state: sample while reset is held, hold afterwards
	always_comb begin
		st_nxt = st_r;
		if (SRST) begin
			st_nxt.cfg = decode(CFG_WORD_DEBUG, CFG_WORD_CLOCK_WATCHDOG, CFG_WORD_PLL); // R21
			st_nxt.word_clock_watchdog = CFG_WORD_CLOCK_WATCHDOG; // R21
			st_nxt.word_pll = CFG_WORD_PLL; // R21
			st_nxt.load_cnt = '0;
			st_nxt.valid = 1'b0;
		end else if (!st_r.valid) begin
			st_nxt.load_cnt = st_r.load_cnt + 2'h1;
			st_nxt.valid = (st_r.load_cnt + 2'h1) >= bcd_pkg::LOAD_CYCLES;
		end
	end

	// register read mux, unmapped reads zero; writes ignored (read only words)
	always_comb begin
		rdata_nxt = '0;
		if (REG_RD) begin
			unique case (REG_ADDR)
				IDX_CLOCK_WATCHDOG: rdata_nxt = st_r.word_clock_watchdog;
				IDX_PLL:            rdata_nxt = st_r.word_pll;
				IDX_STATUS:         rdata_nxt = {29'h0, st_r.cfg.code_protect_active,
					st_r.cfg.debugger_enable, st_r.valid};
				default:            rdata_nxt = '0;
			endcase
		end
	end

	// state registers; synchronous reset loads the sampled words
	always_ff @(posedge CORE_CLK) begin
		st_r <= st_nxt;
		rdata_r <= rdata_nxt;
	end

	assign REG_RDATA = rdata_r;
	assign CFG_OUT   = st_r.cfg;
	assign CFG_VALID = st_r.valid;

	// settings held constant once out of reset
	property p_hold;
		@(posedge CORE_CLK) disable iff (SRST)
		!$past(SRST) |-> $stable(CFG_OUT);
	endproperty
	a_hold: assert property (p_hold) else $error("settings changed while running"); // R21

	property p_debug_cp;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.code_protect_active |-> !CFG_OUT.debugger_enable &&
			CFG_OUT.debug_field_eff == 2'h3;
	endproperty
	a_debug_cp: assert property (p_debug_cp) else $error("debugger on under protect"); // R2

	property p_wdt;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.watchdog_forced_on != CFG_OUT.watchdog_sw_enable_allowed;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog fuse decode wrong"); // R3

	property p_wps;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.watchdog_postscale_eff <= 5'h14;
	endproperty
	a_wps: assert property (p_wps) else $error("postscale above max"); // R4

	property p_wps_clamp;
		@(posedge CORE_CLK) disable iff (SRST)
		$past(SRST) && $past(CFG_WORD_CLOCK_WATCHDOG[20:16]) > 5'h14 |->
			CFG_OUT.watchdog_postscale_eff == 5'h14;
	endproperty
	a_wps_clamp: assert property (p_wps_clamp) else $error("postscale not clamped"); // R5

	property p_fscm;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.fail_safe_monitor_enable |-> CFG_OUT.clock_switch_enable;
	endproperty
	a_fscm: assert property (p_fscm) else $error("monitor without switching"); // R6

	property p_clock_output;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.clock_output_enable |-> (CFG_OUT.primary_osc_mode == bcd_pkg::POSC_DISABLED ||
			CFG_OUT.primary_osc_mode == bcd_pkg::POSC_EXT_CLOCK);
	endproperty
	a_clock_output: assert property (p_clock_output) else $error("clock out with crystal mode"); // R8

	property p_usb;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.usb_pll_enable != CFG_OUT.usb_pll_bypass;
	endproperty
	a_usb: assert property (p_usb) else $error("usb pll enable and bypass agree"); // R15

	property p_mul;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.sys_pll_multiplier inside {[5'h0F:5'h15], 5'h18};
	endproperty
	a_mul: assert property (p_mul) else $error("pll multiplier out of set"); // R17

	// channel bit follows the word sampled in reset
	property p_chan;
		@(posedge CORE_CLK) disable iff (SRST)
		$past(SRST) |-> CFG_OUT.debug_channel_select ==
			$past(CFG_WORD_DEBUG[bcd_pkg::W0_DEBUG_CHAN_BIT]);
	endproperty
	a_chan: assert property (p_chan) else $error("debug channel decode wrong"); // R1

	// protection active when its bit is clear
	property p_prot;
		@(posedge CORE_CLK) disable iff (SRST)
		$past(SRST) |-> CFG_OUT.code_protect_active ==
			!$past(CFG_WORD_DEBUG[bcd_pkg::W0_CODE_PROTECT_BIT]);
	endproperty
	a_prot: assert property (p_prot) else $error("code protect decode wrong"); // R20

	// debugger on only for its one code
	property p_dbg_code;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.debugger_enable |-> CFG_OUT.debug_field_eff == bcd_pkg::DEBUG_EN_CODE;
	endproperty
	a_dbg_code: assert property (p_dbg_code) else $error("debugger on for wrong code"); // R2

	// unprotected field passes through unchanged
	property p_dbg_free;
		@(posedge CORE_CLK) disable iff (SRST)
		$past(SRST) && $past(CFG_WORD_DEBUG[bcd_pkg::W0_CODE_PROTECT_BIT]) |->
			CFG_OUT.debug_field_eff == $past(CFG_WORD_DEBUG[bcd_pkg::W0_DEBUG_EN_LSB +: 2]);
	endproperty
	a_dbg_free: assert property (p_dbg_free) else $error("debug field altered"); // R2

	// watchdog fuse follows captured word
	property p_wdt_fuse;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.watchdog_forced_on == st_r.word_clock_watchdog[bcd_pkg::W1_WDT_FUSE_BIT];
	endproperty
	a_wdt_fuse: assert property (p_wdt_fuse) else $error("watchdog fuse mismatch"); // R3

	// listed postscale codes pass unchanged
	property p_wps_pass;
		@(posedge CORE_CLK) disable iff (SRST)
		st_r.word_clock_watchdog[bcd_pkg::W1_WDT_POST_LSB +: 5] <= bcd_pkg::WDT_POST_MAX |->
			CFG_OUT.watchdog_postscale_eff ==
			st_r.word_clock_watchdog[bcd_pkg::W1_WDT_POST_LSB +: 5];
	endproperty
	a_wps_pass: assert property (p_wps_pass) else $error("postscale code altered"); // R4

	// upper switch bit turns both features off
	property p_csm_off;
		@(posedge CORE_CLK) disable iff (SRST)
		st_r.word_clock_watchdog[bcd_pkg::W1_CLK_SW_MON_LSB + 1] |->
			!CFG_OUT.clock_switch_enable && !CFG_OUT.fail_safe_monitor_enable;
	endproperty
	a_csm_off: assert property (p_csm_off) else $error("switching not disabled"); // R6

	// peripheral divisor is a power of two up to 8
	property p_pbdiv;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.periph_bus_div inside {4'h1, 4'h2, 4'h4, 4'h8};
	endproperty
	a_pbdiv: assert property (p_pbdiv) else $error("peripheral divisor out of set"); // R7

	// disable bit keeps clock output off
	property p_clock_output_dis;
		@(posedge CORE_CLK) disable iff (SRST)
		st_r.word_clock_watchdog[bcd_pkg::W1_CLK_OUT_DIS_BIT] |-> !CFG_OUT.clock_output_enable;
	endproperty
	a_clock_output_dis: assert property (p_clock_output_dis) else $error("clock out while disabled"); // R8

	// primary mode follows captured word
	property p_posc;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.primary_osc_mode == st_r.word_clock_watchdog[bcd_pkg::W1_POSC_MODE_LSB +: 2];
	endproperty
	a_posc: assert property (p_posc) else $error("primary mode mismatch"); // R9

	// two-speed start-up follows captured bit
	property p_two_speed_startup_en;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.two_speed_startup_en == st_r.word_clock_watchdog[bcd_pkg::W1_TWO_SPEED_BIT];
	endproperty
	a_two_speed_startup_en: assert property (p_two_speed_startup_en) else $error("two-speed start-up mismatch"); // R10

	// secondary oscillator follows captured bit
	property p_sosc;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.secondary_osc_en == st_r.word_clock_watchdog[bcd_pkg::W1_SOSC_EN_BIT];
	endproperty
	a_sosc: assert property (p_sosc) else $error("secondary oscillator mismatch"); // R11

	// start-up source follows captured field
	property p_fosc;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.startup_osc_select ==
			st_r.word_clock_watchdog[bcd_pkg::W1_STARTUP_OSC_LSB +: 3];
	endproperty
	a_fosc: assert property (p_fosc) else $error("start-up source mismatch"); // R12

	// output divider stays in its set
	property p_odiv;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.sys_pll_out_div inside {9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020,
			9'h040, 9'h100};
	endproperty
	a_odiv: assert property (p_odiv) else $error("pll output divider out of set"); // R14

	// usb bypass follows captured bit
	property p_usb_byp;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.usb_pll_bypass == st_r.word_pll[bcd_pkg::W2_USB_PLL_BYP_BIT];
	endproperty
	a_usb_byp: assert property (p_usb_byp) else $error("usb bypass mismatch"); // R15

	// usb input divider stays in its set
	property p_udiv;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.usb_pll_in_div inside {[4'h1:4'h6], 4'hA, 4'hC};
	endproperty
	a_udiv: assert property (p_udiv) else $error("usb input divider out of set"); // R16

	// system input divider stays in its set
	property p_pdiv;
		@(posedge CORE_CLK) disable iff (SRST)
		CFG_OUT.sys_pll_in_div inside {[4'h1:4'h6], 4'hA, 4'hC};
	endproperty
	a_pdiv: assert property (p_pdiv) else $error("pll input divider out of set"); // R19

	// read data is zero when no read was taken
	property p_rd_idle;
		@(posedge CORE_CLK) disable iff (SRST)
		!$past(REG_RD) |-> REG_RDATA == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without read");

	// pll word read returns the captured word
	property p_rd_word;
		@(posedge CORE_CLK) disable iff (SRST)
		!$past(SRST) && $past(REG_RD) && $past(REG_ADDR) == IDX_PLL |->
			REG_RDATA == st_r.word_pll;
	endproperty
	a_rd_word: assert property (p_rd_word) else $error("pll word read wrong"); // R21

	sequence s_rel;
		$fell(SRST);
	endsequence
	property p_valid;
		@(posedge CORE_CLK) s_rel |-> !CFG_VALID ##[1:4] CFG_VALID;
	endproperty
	a_valid: assert property (p_valid) else $error("valid late after reset"); // R21
endmodule // bcd_boot_config_word_decoder

/* File: bcd_cfg_mem.sv */
// config memory model: programmed words, reserved positions read back as ones except the top bit of word 0, which reads zero
`timescale 1ns/10ps
module bcd_cfg_mem (
	// programmed contents
	input  wire logic [31:0] PROG_W0,
	input  wire logic [31:0] PROG_W1,
	input  wire logic [31:0] PROG_W2,
	// words seen by the decoder
	output logic [31:0]      WORD0,
	output logic [31:0]      WORD1,
	output logic [31:0]      WORD2
);
	// reserved positions hold ones; top bit of word 0 holds zero
	assign WORD0 = (PROG_W0 & 32'h1000_000B) | 32'h6FFF_FFF4;
	assign WORD1 = (PROG_W1 & 32'h009F_F7A7) | 32'hFF60_0858;
	assign WORD2 = (PROG_W2 & 32'h0007_8777) | 32'hFFF8_7888;
endmodule // bcd_cfg_mem

/* File: test_boot_config_word_decoder.sv */
// testbench for the boot configuration word decoder
`timescale 1ns/10ps
module test_boot_config_word_decoder;
	logic              clk   = 1'b0;
	logic              srst  = 1'b1;
	logic [31:0]       p0    = 32'h0;
	logic [31:0]       p1    = 32'h0;
	logic [31:0]       p2    = 32'h0;
	logic [1:0]        addr  = 2'h0;
	logic [31:0]       wdata = 32'h0;
	logic              wr    = 1'b0;
	logic              rd    = 1'b0;
	wire  [31:0]       w0, w1, w2, rdata;
	wire               valid;
	bcd_pkg::bcd_cfg_s co;
	int                errors = 0;
	int                checks = 0;
	int                od[8]  = '{1, 2, 4, 8, 16, 32, 64, 256};
	int                dv[8]  = '{1, 2, 3, 4, 5, 6, 10, 12};

	// config memory and decoder
	bcd_cfg_mem u_mem (.PROG_W0(p0), .PROG_W1(p1), .PROG_W2(p2), .WORD0(w0), .WORD1(w1),
		.WORD2(w2));
	bcd_boot_config_word_decoder DUT (.CORE_CLK(clk), .SRST(srst), .CFG_WORD_DEBUG(w0),
		.CFG_WORD_CLOCK_WATCHDOG(w1), .CFG_WORD_PLL(w2), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .CFG_OUT(co), .CFG_VALID(valid));

	// 100 ns clock
	always #50 clk = ~clk;

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task rd_reg(input logic [1:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task wr_reg(input logic [1:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// program words, pulse reset, wait for settings to be flagged
	task load(input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
		int n;
		@(posedge clk);
		p0   <= a;
		p1   <= b;
		p2   <= c;
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		n = 0;
		while (valid !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("vdly", 1, n >= 2 && n <= 4);
	endtask

	// every field code swept through one index
	task t_decode;
		logic [2:0] k;
		logic [1:0] m;
		logic       b;
		for (int i = 0; i < 32; i++) begin
			k = 3'(i);
			m = 2'(i);
			b = i[0];
			load({3'h0, i[2], 24'h0, b, 1'b0, m}, {8'h0, b, 2'h0, 5'(i), m, m, 1'b0, i[3], ~m,
				b, 1'b0, ~b, 2'h0, k}, {13'h0, k, b, 4'h0, k, 1'b0, k, 1'b0, ~k});
			chk("chan", b, co.debug_channel_select);
			chk("prot", !i[2], co.code_protect_active);
			chk("dbgf", i[2] ? m : 2'h3, co.debug_field_eff);
			chk("dbge", i[2] && m == 2'h2, co.debugger_enable);
			chk("wdon", b, co.watchdog_forced_on);
			chk("wdsw", !b, co.watchdog_sw_enable_allowed);
			chk("wdps", i > 20 ? 20 : i, co.watchdog_postscale_eff);
			chk("cksw", !m[1], co.clock_switch_enable);
			chk("fscm", m == 2'h0, co.fail_safe_monitor_enable);
			chk("pbdv", 1 << m, co.periph_bus_div);
			chk("clock_output", !i[3] && m[1] == m[0], co.clock_output_enable);
			chk("posc", 2'(~m), co.primary_osc_mode);
			chk("two_speed_startup_en", b, co.two_speed_startup_en);
			chk("sosc", !b, co.secondary_osc_en);
			chk("fosc", k, co.startup_osc_select);
			chk("podv", od[k], co.sys_pll_out_div);
			chk("upen", !b, co.usb_pll_enable);
			chk("upby", b, co.usb_pll_bypass);
			chk("updv", dv[k], co.usb_pll_in_div);
			chk("pmul", 15 + k + (k == 3'h7 ? 2 : 0), co.sys_pll_multiplier);
			chk("pidv", dv[~k], co.sys_pll_in_div);
		end
		$display("decode test done");
	endtask

	// words change while running: reads and settings keep captured values
	task t_regs;
		logic [31:0] d, e1, e2;
		e1 = w1;
		e2 = w2;
		@(posedge clk);
		p1 <= ~p1;
		p2 <= ~p2;
		wr_reg(2'h0, 32'h0);
		rd_reg(2'h0, d);
		chk("reg0", e1, d);
		rd_reg(2'h1, d);
		chk("reg1", e2, d);
		rd_reg(2'h2, d);
		chk("reg2", 32'h1, d);
		rd_reg(2'h3, d);
		chk("reg3", 32'h0, d);
		@(posedge clk);
		#1;
		chk("idle", 32'h0, rdata);
		chk("hold", 3'h7, co.startup_osc_select);
		$display("register test done");
	endtask

	task finish_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// main sequence after the start-up reset
	initial begin
		repeat (4) @(posedge clk);
		t_decode;
		t_regs;
		finish_test;
	end

	// watchdog against a hang
	initial begin
		#400000;
		errors++;
		finish_test;
	end
endmodule // test_boot_config_word_decoder
